/* File: gearing_io.sv */
// Local design decisions: the address map and the AXI4-Lite slave port.
`timescale 1ns/10ps
// Overview of operation
// - diff port is input or emulated output
// - opto pair accepts up to 500 kHz
// - opto pair sampled every 2 us
// - diff input decoded up to 3 MHz
// - pulse/dir, cw/ccw or quadrature decode
// - emulated channels never exceed 3 MHz
// - emulated A and B in quadrature
// - A, B, index from primary position
// - emulation resolution sets pulses per turn
// - zero pulse offset adjustable and held
// - format 0 source 1: diff quadrature
// - format 0 source 2: opto quadrature
// - tertiary 0, mode 11: serial input
// - command pulse scaling is adjustable
// - slave follows master's emulated output
module gearing_io
   import gearing_pkg::*;
#(
   parameter int POS_W = 16
)
(
   // clock and reset
   input logic aclk,
   input logic aresetn,
   // axi4-lite write address
   input logic [7:0] s_axi_awaddr,
   input logic [2:0] s_axi_awprot,
   input logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input logic [31:0] s_axi_wdata,
   input logic [3:0] s_axi_wstrb,
   input logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input logic s_axi_bready,
   // axi4-lite read
   input logic [7:0] s_axi_araddr,
   input logic [2:0] s_axi_arprot,
   input logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input logic s_axi_rready,
   // primary feedback, one turn = 2**POS_W counts
   input logic [POS_W-1:0] primary_position,
   // differential gearing port
   input logic diff_a_in,
   input logic diff_b_in,
   output logic diff_a_out,
   output logic diff_b_out,
   output logic diff_z_out,
   output logic diff_out_en,
   output logic diff_serial_mode,
   // opto input pair
   input logic opto_in1,
   input logic opto_in2,
   // scaled command to the position loop
   output logic [31:0] cmd_position,
   output logic cmd_step,
   output logic cmd_dir
);

   logic [1:0] src_q;
   logic [3:0] fmt_q;
   logic [3:0] emode_q;
   logic [3:0] tfmt_q;
   logic [15:0] eres_q;
   logic [15:0] ezoff_q;
   logic [15:0] gnum_q;
   logic [15:0] gden_q;
   logic [31:0] sec_pos_q;
   logic [31:0] cmd_pos_q;
   logic [7:0] awaddr_q;
   logic aw_have_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic w_have_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic rvalid_q;
   logic [1:0] rresp_q;
   logic [31:0] rdata_q;
   logic do_write;
   logic [31:0] wnew;

   // {step, up}
   function automatic logic [1:0] decode(input logic [3:0] fmt,
      input logic pa, input logic pb, input logic a, input logic b);
      logic [1:0] r;
      r = 2'h0;
      case (fmt)
         FMT_PULSE_DIR:
            r = {a & ~pa, b};
         FMT_CW_CCW:
            r = {(a & ~pa) ^ (b & ~pb), a & ~pa};
         FMT_QUAD:
            r = {(a ^ pa) ^ (b ^ pb), a ^ pb};
         default:
            r = 2'h0;
      endcase
      return r;
   endfunction

   function automatic logic is_mapped(input logic [7:0] addr);
      return addr <= ADDR_STATUS && addr[1:0] == 2'h0;
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] data, input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
      begin
         if (strb[i])
            r[8*i +: 8] = data[8*i +: 8];
      end
      return r;
   endfunction

   function automatic logic [31:0] reg_value(input logic [7:0] addr);
      logic [31:0] r;
      r = 32'h0;
      case (addr)
         ADDR_SOURCE: r = {30'h0, src_q};
         ADDR_FORMAT: r = {28'h0, fmt_q};
         ADDR_EMU_MODE: r = {28'h0, emode_q};
         ADDR_TERT_FORMAT: r = {28'h0, tfmt_q};
         ADDR_EMU_RES: r = {16'h0, eres_q};
         ADDR_EMU_ZOFF: r = {16'h0, ezoff_q};
         ADDR_GEAR_NUM: r = {16'h0, gnum_q};
         ADDR_GEAR_DEN: r = {16'h0, gden_q};
         ADDR_SEC_POS: r = sec_pos_q;
         ADDR_CMD_POS: r = cmd_pos_q;
         ADDR_STATUS:
            r = {29'h0, diff_serial_mode, diff_out_en, cmd_dir};
         default: r = 32'h0;
      endcase
      return r;
   endfunction

   // write channel: address and data taken in either order
   assign s_axi_awready = !aw_have_q && !bvalid_q;
   assign s_axi_wready = !w_have_q && !bvalid_q;
   assign do_write = aw_have_q && w_have_q && !bvalid_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = !rvalid_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rresp = rresp_q;
   assign s_axi_rdata = rdata_q;

   always_comb
   begin
      wnew = merge(reg_value(awaddr_q), wdata_q, wstrb_q);
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_have_q <= 1'b0;
         awaddr_q <= 8'h00;
         w_have_q <= 1'b0;
         wdata_q <= 32'h0;
         wstrb_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_have_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_have_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (do_write)
         begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= is_mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
         end
         else if (bvalid_q && s_axi_bready)
            bvalid_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid_q <= 1'b0;
         rresp_q <= RESP_OKAY;
         rdata_q <= 32'h0;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         rvalid_q <= 1'b1;
         rresp_q <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
         rdata_q <= reg_value(s_axi_araddr);
      end
      else if (rvalid_q && s_axi_rready)
         rvalid_q <= 1'b0;
   end

   // settings; count registers are read-only and ignore writes
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         src_q <= SOURCE_RST;
         fmt_q <= FORMAT_RST;
         emode_q <= EMU_MODE_RST;
         tfmt_q <= TERT_RST;
         eres_q <= EMU_RES_RST;
         ezoff_q <= EMU_ZOFF_RST;
         gnum_q <= GEAR_NUM_RST;
         gden_q <= GEAR_DEN_RST;
      end
      else if (do_write)
      begin
         case (awaddr_q)
            ADDR_SOURCE: src_q <= wnew[1:0];
            ADDR_FORMAT: fmt_q <= wnew[3:0];
            ADDR_EMU_MODE: emode_q <= wnew[3:0];
            ADDR_TERT_FORMAT: tfmt_q <= wnew[3:0];
            ADDR_EMU_RES: eres_q <= wnew[15:0];
            ADDR_EMU_ZOFF: ezoff_q <= wnew[15:0];
            ADDR_GEAR_NUM: gnum_q <= wnew[15:0];
            ADDR_GEAR_DEN: gden_q <= wnew[15:0];
            default: ;
         endcase
      end
   end

   assign diff_out_en = emode_q == EMU_OUTPUT;
   // serial encoder takes the port over
   assign diff_serial_mode = tfmt_q == TERT_SERIAL && emode_q == EMU_SERIAL;

   // ---- command inputs ----
   logic da_q;
   logic db_q;
   logic dpa_q;
   logic dpb_q;
   logic oa_q;
   logic ob_q;
   logic opa_q;
   logic opb_q;
   logic [7:0] osamp_q;
   logic osamp_tick;
   logic diff_in_ok;
   logic [1:0] dstep;
   logic [1:0] ostep;
   logic [1:0] sel;

   assign osamp_tick = osamp_q == 8'(OPTO_SAMPLE_CYC - 1);
   assign diff_in_ok = !diff_out_en && !diff_serial_mode;

   // opto pair sampled on a fixed period
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         osamp_q <= 8'h00;
      else
         osamp_q <= osamp_tick ? 8'h00 : osamp_q + 8'h01;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         {da_q, db_q, dpa_q, dpb_q} <= 4'h0;
         {oa_q, ob_q, opa_q, opb_q} <= 4'h0;
      end
      else
      begin
         {da_q, db_q} <= {diff_a_in, diff_b_in};
         {dpa_q, dpb_q} <= {da_q, db_q};
         // 2 us sampling resolves 500 kHz
         if (osamp_tick)
         begin
            {oa_q, ob_q} <= {opto_in1, opto_in2};
            {opa_q, opb_q} <= {oa_q, ob_q};
         end
      end
   end

   // format chosen by the format setting
   assign dstep = decode(fmt_q, dpa_q, dpb_q, da_q, db_q);
   // opto edge seen once per sample period only
   assign ostep = decode(fmt_q, opa_q, opb_q, oa_q, ob_q) &
      {2{osamp_tick}};

   always_comb
   begin
      sel = 2'h0;
      if (src_q == SRC_DIFF && diff_in_ok)
         sel = dstep;
      else if (src_q == SRC_OPTO)
         sel = ostep;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         sec_pos_q <= 32'h0;
      else if (fmt_q == FMT_QUAD && sel[1])
         sec_pos_q <= sel[0] ? sec_pos_q + 32'h1 : sec_pos_q - 32'h1;
   end

   // fractional gearing: num per pulse, den per count
   logic signed [31:0] resid_q;
   logic signed [31:0] resid_in;
   logic signed [31:0] den_s;

   assign den_s = {16'h0, gden_q};

   always_comb
   begin
      resid_in = resid_q;
      if (sel[1])
         resid_in = sel[0] ? resid_q + {16'h0, gnum_q}
            : resid_q - {16'h0, gnum_q};
   end

   // follows velocity and direction of pulses
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         resid_q <= 32'sh0;
         cmd_pos_q <= 32'h0;
         cmd_step <= 1'b0;
         cmd_dir <= 1'b0;
      end
      else
      begin
         resid_q <= resid_in;
         cmd_step <= 1'b0;
         // large ratios drain one count a clock
         if (gden_q != 16'h0 && resid_in >= den_s)
         begin
            resid_q <= resid_in - den_s;
            cmd_pos_q <= cmd_pos_q + 32'h1;
            cmd_step <= 1'b1;
            cmd_dir <= 1'b1;
         end
         else if (gden_q != 16'h0 && resid_in <= -den_s)
         begin
            resid_q <= resid_in + den_s;
            cmd_pos_q <= cmd_pos_q - 32'h1;
            cmd_step <= 1'b1;
            cmd_dir <= 1'b0;
         end
      end
   end

   assign cmd_position = cmd_pos_q;

   // ---- encoder emulation ----
   logic [17:0] span;
   logic [17:0] tgt_q;
   logic [17:0] ecnt_q;
   logic [POS_W-1:0] rel;
   logic [POS_W+17:0] prod;
   logic signed [18:0] diff;
   logic up;
   logic [3:0] gap_q;
   logic last_up_q;
   logic moved_q;

   assign span = {eres_q, 2'b00};
   // index shifted by the zero offset
   assign rel = primary_position - ezoff_q[POS_W-1:0];
   // quarter counts per turn = 4 x resolution
   assign prod = rel * span;
   assign diff = $signed({1'b0, tgt_q}) - $signed({1'b0, ecnt_q});
   // shortest way round the turn
   assign up = (diff > 19'sh0 && diff <= $signed({2'b00, eres_q, 1'b0}))
      || diff < -$signed({2'b00, eres_q, 1'b0});

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         tgt_q <= 18'h0;
      else
         tgt_q <= prod[POS_W +: 18];
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ecnt_q <= 18'h0;
         gap_q <= 4'h0;
         last_up_q <= 1'b0;
         moved_q <= 1'b0;
      end
      else if (ecnt_q >= span)
         ecnt_q <= 18'h0;
      else if (gap_q != 4'h0)
         gap_q <= gap_q - 4'h1;
      // turn-around right after a step would toggle one channel twice
      else if (moved_q && diff != 19'sh0 && up != last_up_q)
         moved_q <= 1'b0;
      // one step per spacing caps channel rate
      else if (diff == 19'sh0)
         moved_q <= 1'b0;
      else
      begin
         gap_q <= 4'(EMU_STEP_CYC - 1);
         moved_q <= 1'b1;
         last_up_q <= up;
         if (up)
            ecnt_q <= (ecnt_q + 18'h1 == span) ? 18'h0 : ecnt_q + 18'h1;
         else
            ecnt_q <= (ecnt_q == 18'h0) ? span - 18'h1 : ecnt_q - 18'h1;
      end
   end

   // gray sequence keeps exact 90 degrees
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         diff_a_out <= 1'b0;
         diff_b_out <= 1'b0;
         diff_z_out <= 1'b0;
      end
      else
      begin
         diff_a_out <= ecnt_q[1] ^ ecnt_q[0];
         diff_b_out <= ecnt_q[1];
         diff_z_out <= ecnt_q == 18'h0 && span != 18'h0;
      end
   end

endmodule

/* File: gearing_pkg.sv */
package gearing_pkg;
   // register byte addresses
   localparam logic [7:0] ADDR_SOURCE = 8'h00;
   localparam logic [7:0] ADDR_FORMAT = 8'h04;
   localparam logic [7:0] ADDR_EMU_MODE = 8'h08;
   localparam logic [7:0] ADDR_TERT_FORMAT = 8'h0C;
   localparam logic [7:0] ADDR_EMU_RES = 8'h10;
   localparam logic [7:0] ADDR_EMU_ZOFF = 8'h14;
   localparam logic [7:0] ADDR_GEAR_NUM = 8'h18;
   localparam logic [7:0] ADDR_GEAR_DEN = 8'h1C;
   localparam logic [7:0] ADDR_SEC_POS = 8'h20;
   localparam logic [7:0] ADDR_CMD_POS = 8'h24;
   localparam logic [7:0] ADDR_STATUS = 8'h28;
   // field values
   localparam logic [1:0] SRC_NONE = 2'h0;
   localparam logic [1:0] SRC_DIFF = 2'h1;
   localparam logic [1:0] SRC_OPTO = 2'h2;
   localparam logic [3:0] FMT_QUAD = 4'h0;
   localparam logic [3:0] FMT_PULSE_DIR = 4'h1;
   localparam logic [3:0] FMT_CW_CCW = 4'h2;
   localparam logic [3:0] EMU_INPUT = 4'h0;
   localparam logic [3:0] EMU_OUTPUT = 4'h1;
   localparam logic [3:0] EMU_SERIAL = 4'hB;
   localparam logic [3:0] TERT_SERIAL = 4'h0;
   // values after reset
   localparam logic [1:0] SOURCE_RST = 2'h0;
   localparam logic [3:0] FORMAT_RST = 4'h0;
   localparam logic [3:0] EMU_MODE_RST = 4'h0;
   localparam logic [3:0] TERT_RST = 4'hF;
   localparam logic [15:0] EMU_RES_RST = 16'h0400;
   localparam logic [15:0] EMU_ZOFF_RST = 16'h0000;
   localparam logic [15:0] GEAR_NUM_RST = 16'h0001;
   localparam logic [15:0] GEAR_DEN_RST = 16'h0001;
   // timing
   localparam int CLK_KHZ = 10000;
   localparam int OPTO_SAMPLE_NS = 2000;
   localparam int CLK_NS = 100;
   localparam int OPTO_SAMPLE_CYC = OPTO_SAMPLE_NS / CLK_NS;
   localparam int OPTO_MAX_KHZ = 500;
   localparam int DIFF_MAX_KHZ = 3000;
   localparam int EMU_MAX_KHZ = 3000;
   // four quadrature steps make one channel period
   localparam int EMU_STEP_CYC =
      (CLK_KHZ + 4 * EMU_MAX_KHZ - 1) / (4 * EMU_MAX_KHZ);
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: gearing_partner.sv */
`timescale 1ns/10ps
// far-side controller: quadrature encoder or pulse source on one pair
module gearing_partner
(
   // clock
   input logic aclk,
   // 0 drives the diff pair, 1 drives the opto pair
   input logic sel_opto,
   // lines
   output logic diff_a,
   output logic diff_b,
   output logic opto_1,
   output logic opto_2
);
   logic x = 1'b0;
   logic y = 1'b0;
   logic [1:0] idx = 2'h0;
   // unused pair parked low so it never counts
   assign diff_a = sel_opto ? 1'b0 : x;
   assign diff_b = sel_opto ? 1'b0 : y;
   assign opto_1 = sel_opto ? x : 1'b0;
   assign opto_2 = sel_opto ? y : 1'b0;
   task automatic quad(input bit up, input int n, input int gap);
      for (int i = 0; i < n; i++)
      begin
         idx = up ? idx + 2'h1 : idx - 2'h1;
         @(posedge aclk);
         x <= idx[1] ^ idx[0];
         y <= idx[1];
         repeat (gap) @(posedge aclk);
      end
   endtask
   // pulses on one line, level on other
   task automatic pulses(input bit on_y, input bit lvl, input int n,
                         input int gap);
      @(posedge aclk);
      x <= on_y ? lvl : 1'b0;
      y <= on_y ? 1'b0 : lvl;
      repeat (gap) @(posedge aclk);
      for (int i = 0; i < n; i++)
      begin
         if (on_y) y <= 1'b1; else x <= 1'b1;
         repeat (gap) @(posedge aclk);
         if (on_y) y <= 1'b0; else x <= 1'b0;
         repeat (gap) @(posedge aclk);
      end
      x <= 1'b0;
      idx = 2'h0;
   endtask
endmodule

/* File: gearing_io_props.sv */
`timescale 1ns/10ps
module gearing_io_props
(
   // clock and reset
   input logic aclk,
   input logic aresetn,
   // bus answers
   input logic s_axi_bvalid,
   input logic s_axi_bready,
   input logic [1:0] s_axi_bresp,
   input logic s_axi_arready,
   input logic s_axi_rvalid,
   input logic s_axi_rready,
   input logic [31:0] s_axi_rdata,
   // emulated encoder
   input logic diff_a_out,
   input logic diff_b_out,
   input logic diff_z_out,
   input logic diff_out_en,
   input logic diff_serial_mode,
   // command
   input logic [31:0] cmd_position,
   input logic cmd_step,
   input logic cmd_dir
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
   chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
   chk_ar_gate: assert property (s_axi_arready == !s_axi_rvalid)
      else $error("arready not gated by rvalid");
   chk_emu_gray: assert property (!($changed(diff_a_out) &&
      $changed(diff_b_out))) else $error("a and b moved together");
   chk_a_rate: assert property ($changed(diff_a_out) |=>
      $stable(diff_a_out)) else $error("channel a too fast");
   chk_b_rate: assert property ($changed(diff_b_out) |=>
      $stable(diff_b_out)) else $error("channel b too fast");
   chk_index_gate: assert property (diff_z_out |->
      !diff_a_out && !diff_b_out) else $error("index off quarter zero");
   chk_mode_excl: assert property (diff_serial_mode |->
      !diff_out_en) else $error("serial and output both on");
   chk_step_move: assert property (cmd_step |-> cmd_position ==
      $past(cmd_position) + (cmd_dir ? 32'h1 : 32'hFFFFFFFF))
      else $error("step moved position wrongly");
   chk_still_pos: assert property (!cmd_step |->
      $stable(cmd_position)) else $error("position moved without step");
   cover property (cmd_step && !cmd_dir);
   cover property (diff_z_out);
   cover property (diff_serial_mode);
endmodule
bind gearing_io gearing_io_props gearing_io_props_inst (.aclk, .aresetn,
   .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arready,
   .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .diff_a_out, .diff_b_out,
   .diff_z_out, .diff_out_en, .diff_serial_mode, .cmd_position, .cmd_step,
   .cmd_dir);

/* File: gearing_io_tb.sv */
`timescale 1ns/10ps
module gearing_io_tb;
   import gearing_pkg::*;
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_fail++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, cmd_position, rv;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, sel_opto = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, diff_a_in, diff_b_in, opto_in1, opto_in2;
   logic diff_a_out, diff_b_out, diff_z_out, diff_out_en;
   logic diff_serial_mode, cmd_step, cmd_dir, done;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   // primary feedback driven apart from secondary inputs
   logic [15:0] primary_position = 16'h0000;
   logic [7:0] ra[8] = '{ADDR_SOURCE, ADDR_FORMAT, ADDR_EMU_MODE,
      ADDR_TERT_FORMAT, ADDR_EMU_RES, ADDR_EMU_ZOFF, ADDR_GEAR_NUM,
      ADDR_GEAR_DEN};
   logic [31:0] rx[8] = '{32'(SOURCE_RST), 32'(FORMAT_RST),
      32'(EMU_MODE_RST), 32'(TERT_RST), 32'(EMU_RES_RST),
      32'(EMU_ZOFF_RST), 32'(GEAR_NUM_RST), 32'(GEAR_DEN_RST)};
   int n_fail = 0;
   int compares = 0;
   int cyc = 0;
   gearing_io gearing_io_inst (.*);
   gearing_partner gearing_partner_inst (.aclk(aclk), .sel_opto(sel_opto),
      .diff_a(diff_a_in), .diff_b(diff_b_in), .opto_1(opto_in1),
      .opto_2(opto_in2));
   always #50 aclk = ~aclk;
   // hang guard, well above the expected few hundred cycles
   always @(posedge aclk)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         n_fail++;
         summarize();
      end
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      done = 1'b0;
      // values read here are those sampled at this rising edge
      while (!done)
      begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
            s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid && s_axi_bready)
         begin
            rs = s_axi_bresp;
            s_axi_bready <= 1'b0;
            done = 1'b1;
         end
      end
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      done = 1'b0;
      while (!done)
      begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready)
            s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid && s_axi_rready)
         begin
            rv = s_axi_rdata;
            rs = s_axi_rresp;
            s_axi_rready <= 1'b0;
            done = 1'b1;
         end
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      rd(a);
      `CHK(rv, e)
      `CHK(rs, RESP_OKAY)
   endtask
   task automatic summarize();
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial
   begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i < 8; i++)
         rchk(ra[i], rx[i]);
      wr(8'h2C, 32'h1);
      `CHK(rs, RESP_SLVERR)
      rd(8'h2C);
      `CHK(rs, RESP_SLVERR)
      `CHK(rv, 32'h0)
      $display("test reset_map done");
      wr(ADDR_SOURCE, 32'(SRC_DIFF));
      gearing_partner_inst.quad(1'b1, 8, 4);
      rchk(ADDR_SEC_POS, 32'h8);
      gearing_partner_inst.quad(1'b0, 3, 4);
      rchk(ADDR_SEC_POS, 32'h5);
      rchk(ADDR_CMD_POS, 32'h5);
      $display("test diff_quad done");
      wr(ADDR_GEAR_NUM, 32'h3);
      wr(ADDR_GEAR_DEN, 32'h2);
      wr(ADDR_FORMAT, 32'(FMT_PULSE_DIR));
      gearing_partner_inst.pulses(1'b0, 1'b1, 4, 3);
      rchk(ADDR_CMD_POS, 32'hB);
      wr(ADDR_FORMAT, 32'(FMT_CW_CCW));
      gearing_partner_inst.pulses(1'b1, 1'b0, 2, 3);
      rchk(ADDR_CMD_POS, 32'h8);
      rchk(ADDR_SEC_POS, 32'h5);
      wr(ADDR_CMD_POS, 32'h0);
      `CHK(rs, RESP_OKAY)
      rchk(ADDR_CMD_POS, 32'h8);
      `CHK(cmd_position, 32'h8)
      $display("test gearing done");
      wr(ADDR_GEAR_NUM, 32'h1);
      wr(ADDR_GEAR_DEN, 32'h1);
      wr(ADDR_FORMAT, 32'(FMT_QUAD));
      wr(ADDR_SOURCE, 32'(SRC_OPTO));
      sel_opto <= 1'b1;
      gearing_partner_inst.quad(1'b1, 4, 50);
      rchk(ADDR_SEC_POS, 32'h9);
      rchk(ADDR_CMD_POS, 32'hC);
      $display("test opto_quad done");
      // 5 quarters of a 16-quarter turn
      primary_position <= 16'h5000;
      wr(ADDR_EMU_RES, 32'h4);
      wr(ADDR_EMU_MODE, 32'(EMU_OUTPUT));
      repeat (30) @(posedge aclk);
      `CHK(diff_out_en, 1'b1)
      `CHK({diff_z_out, diff_b_out, diff_a_out}, 3'b001)
      wr(ADDR_EMU_ZOFF, 32'h5000);
      repeat (30) @(posedge aclk);
      `CHK({diff_z_out, diff_b_out, diff_a_out}, 3'b100)
      rchk(ADDR_EMU_ZOFF, 32'h5000);
      rchk(ADDR_STATUS, 32'h3);
      $display("test emulation done");
      wr(ADDR_EMU_MODE, 32'(EMU_SERIAL));
      wr(ADDR_TERT_FORMAT, 32'(TERT_SERIAL));
      repeat (2) @(posedge aclk);
      `CHK({diff_serial_mode, diff_out_en}, 2'b10)
      rchk(ADDR_STATUS, 32'h5);
      $display("test serial_mode done");
      summarize();
   end
endmodule
